// [core/emb_irq_router.sv]
// Purpose: route embedded event flags to two interrupt pins and status
// Assumes: simple byte register port; gate, latch and mask bits arrive
//          as inputs from registers held elsewhere in the device
// Notes:   pins and read data are registered, one cycle behind
//          a status read returns the flags from before its own clear
//          reserved route bits read back exactly as written
//
// Function
// - each pin ORs its enabled event sources
// - state machine n routes first pin via bit n-1
// - classifier bits 3..0 route to first pin
// - first-pin routing needs first gate bit set
// - long-counter timeout to second pin, bit 7
// - significant motion to second pin, bit 5
// - tilt to second pin, bit 4
// - step recognition to second pin, bit 3
// - second-pin routing needs second gate bit set
// - state machine n routes second pin via bit n-1
// - classifier bits 3..0 route to second pin
// - all routing bits reset to disabled
// - status bits 7,5 long count, sig motion
// - status bits 4,3 tilt and step
// - state machine n status in bit n-1
// - classifier status bits 3..0, upper zero
// - status one means event detected
// - latch mode bit selects latched requests
// - latched read clears bits unless ack-kept
`default_nettype none

module emb_irq_router #(
    parameter int unsigned SM_COUNT  = 8,
    parameter int unsigned CLS_COUNT = 4
) (
    // clock and reset
    input  wire logic                 i_mclk,
    input  wire logic                 i_sys_rst,
    // register port
    input  wire logic [7:0]           i_reg_addr,
    input  wire logic                 i_reg_wr,
    input  wire logic [7:0]           i_reg_wdata,
    input  wire logic                 i_reg_rd,
    output logic      [7:0]           o_reg_rdata,
    // configuration bits held in other registers
    input  wire logic                 i_pin_first_embedded_gate,
    input  wire logic                 i_pin_second_embedded_gate,
    input  wire logic                 i_embedded_latch_mode,
    input  wire logic [7:0]           i_ack_keep_mask,
    // event sources
    input  wire logic [SM_COUNT-1:0]  i_state_machine_event,
    input  wire logic [CLS_COUNT-1:0] i_classifier_event,
    input  wire logic                 i_long_count_event,
    input  wire logic                 i_sig_motion_event,
    input  wire logic                 i_tilt_event,
    input  wire logic                 i_step_event,
    // interrupt pins
    output logic                      o_irq_pin_first,
    output logic                      o_irq_pin_second
);

    ////////////////////////////////////////////////////////////////////////
    // routing registers

    logic [7:0] sm_route_first_reg;
    logic [7:0] sm_route_first_next;
    logic [7:0] cls_route_first_reg;
    logic [7:0] cls_route_first_next;
    logic [7:0] misc_route_second_reg;
    logic [7:0] misc_route_second_next;
    logic [7:0] sm_route_second_reg;
    logic [7:0] sm_route_second_next;
    logic [7:0] cls_route_second_reg;
    logic [7:0] cls_route_second_next;

    // reserved bits are stored as written; the host keeps them zero and
    // they have no source behind them, so they never reach a pin
    always_comb begin
        sm_route_first_next    = sm_route_first_reg;
        cls_route_first_next   = cls_route_first_reg;
        misc_route_second_next = misc_route_second_reg;
        sm_route_second_next   = sm_route_second_reg;
        cls_route_second_next  = cls_route_second_reg;
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                emb_irq_pkg::ADDR_SM_ROUTE_P1: begin
                    sm_route_first_next = i_reg_wdata;
                end
                emb_irq_pkg::ADDR_CLS_ROUTE_P1: begin
                    cls_route_first_next = i_reg_wdata;
                end
                emb_irq_pkg::ADDR_MISC_ROUTE_P2: begin
                    misc_route_second_next = i_reg_wdata;
                end
                emb_irq_pkg::ADDR_SM_ROUTE_P2: begin
                    sm_route_second_next = i_reg_wdata;
                end
                emb_irq_pkg::ADDR_CLS_ROUTE_P2: begin
                    cls_route_second_next = i_reg_wdata;
                end
                default: begin
                    // status and unmapped offsets ignore writes
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            sm_route_first_reg    <= emb_irq_pkg::ROUTE_RESET;
            cls_route_first_reg   <= emb_irq_pkg::ROUTE_RESET;
            misc_route_second_reg <= emb_irq_pkg::ROUTE_RESET;
            sm_route_second_reg   <= emb_irq_pkg::ROUTE_RESET;
            cls_route_second_reg  <= emb_irq_pkg::ROUTE_RESET;
        end else begin
            sm_route_first_reg    <= sm_route_first_next;
            cls_route_first_reg   <= cls_route_first_next;
            misc_route_second_reg <= misc_route_second_next;
            sm_route_second_reg   <= sm_route_second_next;
            cls_route_second_reg  <= cls_route_second_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event vectors in status register layout

    logic [7:0] misc_src;
    logic [7:0] sm_src;
    logic [7:0] cls_src;

    // unused status bits are tied low here and masked again in the bank
    always_comb begin
        misc_src = '0;
        misc_src[emb_irq_pkg::BIT_LONG_COUNT] = i_long_count_event;
        misc_src[emb_irq_pkg::BIT_SIG_MOTION] = i_sig_motion_event;
        misc_src[emb_irq_pkg::BIT_TILT]       = i_tilt_event;
        misc_src[emb_irq_pkg::BIT_STEP]       = i_step_event;
        sm_src = '0;
        sm_src[SM_COUNT-1:0] = i_state_machine_event;
        cls_src = '0;
        cls_src[CLS_COUNT-1:0] = i_classifier_event;
    end

    ////////////////////////////////////////////////////////////////////////
    // read strobes: a status read clears in the same edge that samples it

    logic rd_misc;
    logic rd_sm;
    logic rd_cls;

    assign rd_misc = i_reg_rd
        && (i_reg_addr == emb_irq_pkg::ADDR_MISC_STATUS);
    assign rd_sm   = i_reg_rd
        && (i_reg_addr == emb_irq_pkg::ADDR_SM_STATUS);
    assign rd_cls  = i_reg_rd
        && (i_reg_addr == emb_irq_pkg::ADDR_CLS_STATUS);

    logic [7:0] misc_flags;
    logic [7:0] sm_flags;
    logic [7:0] cls_flags;

    // one bank per status register; all three share the keep mask
    emb_event_flag_bank #(
        .WIDTH (8)
    ) u_misc_bank (
        .i_mclk       (i_mclk),
        .i_sys_rst    (i_sys_rst),
        .i_latch_mode (i_embedded_latch_mode),
        .i_ack_keep   (i_ack_keep_mask),
        .i_used_mask  (emb_irq_pkg::MISC_USED_MASK),
        .i_event      (misc_src),
        .i_read_clear (rd_misc),
        .o_flags      (misc_flags)
    );

    emb_event_flag_bank #(
        .WIDTH (8)
    ) u_sm_bank (
        .i_mclk       (i_mclk),
        .i_sys_rst    (i_sys_rst),
        .i_latch_mode (i_embedded_latch_mode),
        .i_ack_keep   (i_ack_keep_mask),
        .i_used_mask  (emb_irq_pkg::SM_USED_MASK),
        .i_event      (sm_src),
        .i_read_clear (rd_sm),
        .o_flags      (sm_flags)
    );

    emb_event_flag_bank #(
        .WIDTH (8)
    ) u_cls_bank (
        .i_mclk       (i_mclk),
        .i_sys_rst    (i_sys_rst),
        .i_latch_mode (i_embedded_latch_mode),
        .i_ack_keep   (i_ack_keep_mask),
        .i_used_mask  (emb_irq_pkg::CLS_USED_MASK),
        .i_event      (cls_src),
        .i_read_clear (rd_cls),
        .o_flags      (cls_flags)
    );

    ////////////////////////////////////////////////////////////////////////
    // pin routing, registered so the pins never glitch

    logic pin_first_reg;
    logic pin_first_next;
    logic pin_second_reg;
    logic pin_second_next;
    logic [7:0] misc_route_eff;
    logic       sm_hit_first;
    logic       cls_hit_first;
    logic       misc_hit_second;
    logic       sm_hit_second;
    logic       cls_hit_second;

    always_comb begin
        // only the four documented misc enables carry a source
        misc_route_eff = misc_route_second_reg & emb_irq_pkg::MISC_USED_MASK;
        sm_hit_first    = |(sm_flags & sm_route_first_reg);
        cls_hit_first   = |(cls_flags & cls_route_first_reg);
        misc_hit_second = |(misc_flags & misc_route_eff);
        sm_hit_second   = |(sm_flags & sm_route_second_reg);
        cls_hit_second  = |(cls_flags & cls_route_second_reg);
        // the gate masks the whole OR, so route bits left set while the
        // gate is low never leak onto the pin
        pin_first_next = i_pin_first_embedded_gate
            && (sm_hit_first || cls_hit_first);
        pin_second_next = i_pin_second_embedded_gate
            && (misc_hit_second || sm_hit_second
                || cls_hit_second);
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            // both pins low in reset, so no stale request reaches the host
            pin_first_reg  <= 1'b0;
            pin_second_reg <= 1'b0;
        end else begin
            pin_first_reg  <= pin_first_next;
            pin_second_reg <= pin_second_next;
        end
    end

    assign o_irq_pin_first  = pin_first_reg;
    assign o_irq_pin_second = pin_second_reg;

    ////////////////////////////////////////////////////////////////////////
    // read data

    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    always_comb begin
        // the flags sampled here are those before the clearing edge
        rdata_next = rdata_reg;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                emb_irq_pkg::ADDR_SM_ROUTE_P1: begin
                    rdata_next = sm_route_first_reg;
                end
                emb_irq_pkg::ADDR_CLS_ROUTE_P1: begin
                    rdata_next = cls_route_first_reg;
                end
                emb_irq_pkg::ADDR_MISC_ROUTE_P2: begin
                    rdata_next = misc_route_second_reg;
                end
                emb_irq_pkg::ADDR_SM_ROUTE_P2: begin
                    rdata_next = sm_route_second_reg;
                end
                emb_irq_pkg::ADDR_CLS_ROUTE_P2: begin
                    rdata_next = cls_route_second_reg;
                end
                emb_irq_pkg::ADDR_MISC_STATUS: begin
                    rdata_next = misc_flags;
                end
                emb_irq_pkg::ADDR_SM_STATUS: begin
                    rdata_next = sm_flags;
                end
                emb_irq_pkg::ADDR_CLS_STATUS: begin
                    rdata_next = cls_flags;
                end
                default: begin
                    // unmapped offsets read zero; no error is signalled
                    rdata_next = emb_irq_pkg::UNMAPPED_VAL;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            rdata_reg <= emb_irq_pkg::RDATA_RESET;
        end else begin
            // route register reads have no side effect
            rdata_reg <= rdata_next;
        end
    end

    assign o_reg_rdata = rdata_reg;

endmodule

`default_nettype wire

// [core/emb_irq_pkg.sv]
// Purpose: shared constants for the embedded event interrupt router
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   misc bit positions apply to both the misc status and misc routing register
`default_nettype none

package emb_irq_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 8;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] ADDR_SM_ROUTE_P1   = 8'h0b;
    localparam logic [7:0] ADDR_CLS_ROUTE_P1  = 8'h0d;
    localparam logic [7:0] ADDR_MISC_ROUTE_P2 = 8'h0e;
    localparam logic [7:0] ADDR_SM_ROUTE_P2   = 8'h0f;
    localparam logic [7:0] ADDR_CLS_ROUTE_P2  = 8'h11;
    localparam logic [7:0] ADDR_MISC_STATUS   = 8'h12;
    localparam logic [7:0] ADDR_SM_STATUS     = 8'h13;
    localparam logic [7:0] ADDR_CLS_STATUS    = 8'h15;

    ////////////////////////////////////////////////////////////////////////
    // field positions of the misc event registers
    localparam int unsigned BIT_LONG_COUNT = 7;
    localparam int unsigned BIT_SIG_MOTION = 5;
    localparam int unsigned BIT_TILT       = 4;
    localparam int unsigned BIT_STEP       = 3;

    // implemented bits of each register
    localparam logic [7:0] MISC_USED_MASK = 8'hb8;
    localparam logic [7:0] SM_USED_MASK   = 8'hff;
    localparam logic [7:0] CLS_USED_MASK  = 8'h0f;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] ROUTE_RESET  = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET  = 8'h00;
    localparam logic [7:0] UNMAPPED_VAL = 8'h00;

endpackage

`default_nettype wire

// [core/emb_event_flag_bank.sv]
// Purpose: one status register of event flags, latched or live
// Assumes: sources are level or pulse, synchronous to i_mclk
// Notes:   a new event in the clearing cycle keeps its flag set
`default_nettype none

module emb_event_flag_bank #(
    parameter int unsigned WIDTH = 8
) (
    // clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_sys_rst,
    // configuration
    input  wire logic             i_latch_mode,
    input  wire logic [WIDTH-1:0] i_ack_keep,
    input  wire logic [WIDTH-1:0] i_used_mask,
    // events and read side effect
    input  wire logic [WIDTH-1:0] i_event,
    input  wire logic             i_read_clear,
    // flags
    output logic      [WIDTH-1:0] o_flags
);

    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;
    logic [WIDTH-1:0] clear_vec;

    always_comb begin
        clear_vec = i_read_clear ? ~i_ack_keep : '0;
        if (i_latch_mode) begin
            // set wins over clear
            flags_next = (flags_reg & ~clear_vec) | i_event;
        end else begin
            flags_next = i_event;
        end
        flags_next = flags_next & i_used_mask;
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign o_flags = flags_reg;

endmodule

`default_nettype wire

// [tb/emb_irq_router_monitor.sv]
// Purpose: port checks for the embedded event interrupt router
// Assumes: flags one edge and pins two edges behind their events
// Notes:   route registers are hidden here, so checks lean on gate and mode
`default_nettype none

module emb_irq_router_monitor #(
    parameter int unsigned SM_COUNT  = 8,
    parameter int unsigned CLS_COUNT = 4
) (
    // clock and reset
    input wire logic                 i_mclk,
    input wire logic                 i_sys_rst,
    // register port
    input wire logic [7:0]           i_reg_addr,
    input wire logic                 i_reg_wr,
    input wire logic [7:0]           i_reg_wdata,
    input wire logic                 i_reg_rd,
    input wire logic [7:0]           o_reg_rdata,
    // configuration
    input wire logic                 i_pin_first_embedded_gate,
    input wire logic                 i_pin_second_embedded_gate,
    input wire logic                 i_embedded_latch_mode,
    input wire logic [7:0]           i_ack_keep_mask,
    // events
    input wire logic [SM_COUNT-1:0]  i_state_machine_event,
    input wire logic [CLS_COUNT-1:0] i_classifier_event,
    input wire logic                 i_long_count_event,
    input wire logic                 i_sig_motion_event,
    input wire logic                 i_tilt_event,
    input wire logic                 i_step_event,
    // pins
    input wire logic                 o_irq_pin_first,
    input wire logic                 o_irq_pin_second
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    logic any_event;
    logic rd_sm;
    assign any_event = (|i_state_machine_event) | (|i_classifier_event)
        | i_long_count_event | i_sig_motion_event
        | i_tilt_event | i_step_event;
    assign rd_sm = i_reg_rd && i_reg_addr == 8'h13;

    ////////////////////////////////////////////////////////////////////////
    a_first_gate_hold: assert property (
        o_irq_pin_first |-> $past(i_pin_first_embedded_gate)
            || $past(i_pin_first_embedded_gate, 2))
        else $error("first pin high with its gate low");
    a_second_gate_hold: assert property (
        o_irq_pin_second |-> $past(i_pin_second_embedded_gate)
            || $past(i_pin_second_embedded_gate, 2))
        else $error("second pin high with its gate low");
    a_live_pin_cause: assert property (
        (o_irq_pin_first || o_irq_pin_second)
            && !$past(i_embedded_latch_mode, 2) |-> $past(any_event, 2))
        else $error("live pin high with no event");
    a_cls_upper_zero: assert property (
        i_reg_rd && i_reg_addr == 8'h15 |=> o_reg_rdata[7:4] == 4'h0)
        else $error("classifier status upper bits set");
    a_misc_unused_zero: assert property (
        i_reg_rd && i_reg_addr == 8'h12 |=> (o_reg_rdata & 8'h47) == 8'h00)
        else $error("misc status unused bits set");
    a_latched_read_clear: assert property (
        i_embedded_latch_mode && rd_sm && i_ack_keep_mask == 8'h00
            && i_state_machine_event == '0
            ##1 !i_reg_rd && i_state_machine_event == '0
            ##1 rd_sm |=> o_reg_rdata == 8'h00)
        else $error("latched flag survived its read");
    a_live_status: assert property (
        rd_sm && !i_embedded_latch_mode && !$past(i_embedded_latch_mode)
        |=> o_reg_rdata == 8'($past(i_state_machine_event, 2)))
        else $error("live status not following events");
    a_latched_set_seen: assert property (
        i_embedded_latch_mode && i_state_machine_event[0]
            ##1 (!i_reg_rd && i_embedded_latch_mode)[*2]
            ##1 rd_sm |=> o_reg_rdata[0])
        else $error("latched event not reported");

    c_pin_first: cover property (o_irq_pin_first);
    c_pin_second: cover property (o_irq_pin_second);
    c_kept_flag: cover property (
        rd_sm && i_ack_keep_mask[0] ##1 o_reg_rdata[0]);
endmodule

bind emb_irq_router emb_irq_router_monitor #(
    .SM_COUNT(SM_COUNT),
    .CLS_COUNT(CLS_COUNT)
) mon_u (
    .i_mclk, .i_sys_rst, .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_reg_rd,
    .o_reg_rdata, .i_pin_first_embedded_gate, .i_pin_second_embedded_gate,
    .i_embedded_latch_mode, .i_ack_keep_mask, .i_state_machine_event,
    .i_classifier_event, .i_long_count_event, .i_sig_motion_event,
    .i_tilt_event, .i_step_event, .o_irq_pin_first, .o_irq_pin_second
);

`default_nettype wire

// [tb/host_model.sv]
// Purpose: host processor model on the byte register port
// Assumes: a request is taken at the edge after it is raised
// Notes:   tasks start and end 1 ns after an edge, so calls never overlap
`default_nettype none

module host_model (
    // clock
    input  wire logic       i_mclk,
    // register port
    output logic      [7:0] o_reg_addr,
    output logic            o_reg_wr,
    output logic      [7:0] o_reg_wdata,
    output logic            o_reg_rd,
    input  wire logic [7:0] i_reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_reg_addr = 8'h00;
        o_reg_wr = 1'b0;
        o_reg_wdata = 8'h00;
        o_reg_rd = 1'b0;
    end

    // reserved route bits are always written as zero
    function automatic logic [7:0] used(input logic [7:0] a);
        case (a)
            8'h0d, 8'h11: return emb_irq_pkg::CLS_USED_MASK;
            8'h0e: return emb_irq_pkg::MISC_USED_MASK;
            default: return emb_irq_pkg::SM_USED_MASK;
        endcase
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        #1;
        o_reg_addr = a;
        o_reg_wdata = d & used(a);
        o_reg_wr = 1'b1;
        @(posedge i_mclk);
        #1;
        o_reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        #1;
        o_reg_addr = a;
        o_reg_rd = 1'b1;
        @(posedge i_mclk);
        #1;
        o_reg_rd = 1'b0;
        d = i_reg_rdata;
    endtask
endmodule

`default_nettype wire

// [tb/tb.sv]
// Purpose: self-checking bench for the embedded event interrupt router
// Assumes: flag one edge and pin two edges after an event
// Notes:   every drive lands 1 ns after a rising edge
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic            i_mclk = 1'b0;
    logic            i_sys_rst = 1'b1;
    logic [15:0]     ev = 16'h0000;
    logic            gate_first = 1'b1;
    logic            gate_second = 1'b1;
    logic            latch_mode = 1'b1;
    logic [7:0]      keep = 8'h00;
    wire logic [7:0] i_reg_addr;
    wire logic       i_reg_wr;
    wire logic [7:0] i_reg_wdata;
    wire logic       i_reg_rd;
    wire logic [7:0] o_reg_rdata;
    wire logic       o_irq_pin_first;
    wire logic       o_irq_pin_second;
    wire logic [7:0] pins = {6'h00, o_irq_pin_first, o_irq_pin_second};
    int              num_errors = 0;
    int              n_compared = 0;
    int              cycles = 0;
    logic [7:0]      d;
    logic [7:0]      ra;
    logic [7:0]      rv;
    logic [7:0]      sa;
    logic [15:0]     evv;
    logic [1:0]      pins_exp;
    logic [7:0]      regs [8] = '{8'h0b, 8'h0d, 8'h0e, 8'h0f, 8'h11, 8'h12,
                                  8'h13, 8'h15};
    // route addr, route value (also status value), status addr, events
    logic [39:0]     cases [9] = '{
        {8'h0b, 8'h80, 8'h13, 16'h0080},
        {8'h0b, 8'h01, 8'h13, 16'h0001},
        {8'h0d, 8'h08, 8'h15, 16'h0800},
        {8'h0e, 8'h80, 8'h12, 16'h8000},
        {8'h0e, 8'h20, 8'h12, 16'h4000},
        {8'h0e, 8'h10, 8'h12, 16'h2000},
        {8'h0e, 8'h08, 8'h12, 16'h1000},
        {8'h0f, 8'h40, 8'h13, 16'h0040},
        {8'h11, 8'h01, 8'h15, 16'h0100}
    };

    always #5 i_mclk = ~i_mclk;

    emb_irq_router dut_u (
        .i_mclk, .i_sys_rst, .i_reg_addr, .i_reg_wr, .i_reg_wdata,
        .i_reg_rd, .o_reg_rdata,
        .i_pin_first_embedded_gate(gate_first),
        .i_pin_second_embedded_gate(gate_second),
        .i_embedded_latch_mode(latch_mode),
        .i_ack_keep_mask(keep),
        .i_state_machine_event(ev[7:0]),
        .i_classifier_event(ev[11:8]),
        .i_long_count_event(ev[15]),
        .i_sig_motion_event(ev[14]),
        .i_tilt_event(ev[13]),
        .i_step_event(ev[12]),
        .o_irq_pin_first, .o_irq_pin_second
    );

    host_model host_u (
        .i_mclk, .o_reg_addr(i_reg_addr), .o_reg_wr(i_reg_wr),
        .o_reg_wdata(i_reg_wdata), .o_reg_rd(i_reg_rd),
        .i_reg_rdata(o_reg_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask

    task automatic pulse(input logic [15:0] v);
        @(posedge i_mclk);
        #1;
        ev = v;
        @(posedge i_mclk);
        #1;
        ev = 16'h0000;
    endtask

    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge i_mclk);
        #1;
        i_sys_rst = 1'b0;
        chk(pins, 8'h00);
        foreach (regs[i]) begin
            host_u.rd(regs[i], d);
            chk(d, 8'h00);
        end
        host_u.rd(8'h0c, d);
        chk(d, 8'h00);
        $display("test reset values done");
        // status offsets must ignore writes
        foreach (regs[i]) begin
            host_u.wr(regs[i], 8'hff);
            host_u.rd(regs[i], d);
            chk(d, regs[i] > 8'h11 ? 8'h00 : host_u.used(regs[i]));
            host_u.wr(regs[i], 8'h00);
        end
        $display("test register access done");
        for (int g = 1; g >= 0; g--) begin
            gate_first = g[0];
            gate_second = g[0];
            foreach (cases[i]) begin
                {ra, rv, sa, evv} = cases[i];
                pins_exp = (ra == 8'h0b || ra == 8'h0d) ? 2'b10 : 2'b01;
                host_u.wr(ra, rv);
                pulse(evv);
                @(posedge i_mclk);
                #1;
                chk(pins, {6'h00, pins_exp & {2{g[0]}}});
                host_u.rd(sa, d);
                chk(d, rv);
                host_u.rd(sa, d);
                chk(d, 8'h00);
                chk(pins, 8'h00);
                host_u.wr(ra, 8'h00);
            end
        end
        $display("test routing table done");
        gate_first = 1'b1;
        gate_second = 1'b1;
        keep = 8'h01;
        host_u.wr(8'h0b, 8'h01);
        pulse(16'h0001);
        host_u.rd(8'h13, d);
        chk(d, 8'h01);
        host_u.rd(8'h13, d);
        chk(d, 8'h01);
        chk(pins, 8'h02);
        keep = 8'h00;
        host_u.rd(8'h13, d);
        chk(d, 8'h01);
        host_u.rd(8'h13, d);
        chk(d, 8'h00);
        $display("test acknowledge mask done");
        latch_mode = 1'b0;
        ev = 16'h0001;
        host_u.rd(8'h13, d);
        chk(d, 8'h01);
        chk(pins, 8'h02);
        ev = 16'h0000;
        repeat (3) @(posedge i_mclk);
        host_u.rd(8'h13, d);
        chk(d, 8'h00);
        chk(pins, 8'h00);
        $display("test live mode done");
        stop_test();
    end
endmodule

`default_nettype wire
